// ---- hdl/conv_ctrl_pkg.sv ----
package conv_ctrl_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	// Conversion time in ns (plain default, not a documented figure)
	localparam int CONV_TIME_NS = 4000;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_CNT_W = 12;

	// ****************************************
	// Geometry and reset values
	// ****************************************
	localparam int NUM_CHANNELS = 8;
	localparam int SAMPLE_W = 18;
	localparam logic BUSY_RST = 1'b0;
	localparam logic PWR_DOWN_RST = 1'b0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONVERT = 2'b01,
		ST_DOWN = 2'b11
	} conv_state_t;

endpackage : conv_ctrl_pkg

// ---- hdl/conv_power_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none

module conv_power_ctrl
	import conv_ctrl_pkg::*;
#(
	parameter int CONV_LEN = CONV_CYCLES,
	parameter int CH = NUM_CHANNELS,
	parameter int DW = SAMPLE_W
) (
	// Clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	// Host pins
	input wire logic I_CONVERSION_START_INPUT,
	input wire logic I_POWER_DOWN_INPUT,
	input wire logic I_IO_MODE_SELECT,
	input wire logic I_CS_N,
	// Echo clock from the serial shifter
	input wire logic I_ECHO_CLOCK_NEXT,
	// Analog front end, as digitised positive and negative inputs per channel
	input wire logic [CH*DW-1:0] I_CH_POS,
	input wire logic [CH*DW-1:0] I_CH_NEG,
	// Status outputs
	output logic O_BUSY,
	output logic O_POWERED_DOWN,
	output logic O_DIFF_IO_MODE,
	output logic O_SAMPLE_HOLD,
	output logic O_GLOBAL_RESET,
	output logic O_ECHO_CLOCK_OUTPUT,
	output logic [CH*DW-1:0] O_RESULT,
	output logic O_RESULT_VALID
);

	// ****************************************
	// Input synchronisation
	// ****************************************
	logic cnv_s, pd_s, mode_s, cs_n_s;
	logic cnv_prev_q, pd_prev_q;
	logic glob_rst_q;
	logic rst_all;

	// Global reset acts like the external reset below, except on the synchroniser, the edge history and the mode flop
	assign rst_all = I_RST | glob_rst_q;

	pin_sync #(.WIDTH(4)) u_sync (
		.clk(I_CORE_CLK),
		.rst(I_RST),
		.d({I_CONVERSION_START_INPUT, I_POWER_DOWN_INPUT, I_IO_MODE_SELECT, I_CS_N}),
		.q({cnv_s, pd_s, mode_s, cs_n_s})
	);

	// Edge history on the synchronised pins; the global reset leaves it alone,
	// since power-down is still high then and a cleared history would see a false rise
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			cnv_prev_q <= 1'b0;
			pd_prev_q <= 1'b0;
		end else begin
			cnv_prev_q <= cnv_s;
			pd_prev_q <= pd_s;
		end
	end

	logic cnv_rise, pd_rise;
	// Chip select deliberately absent from the start term
	assign cnv_rise = cnv_s & ~cnv_prev_q;
	assign pd_rise = pd_s & ~pd_prev_q;

	// ****************************************
	// Conversion state machine
	// ****************************************
	conv_state_t state_q, state_d;
	logic [CONV_CNT_W-1:0] cnt_q;
	logic done;
	assign done = (state_q == ST_CONVERT) && (cnt_q == CONV_CNT_W'(CONV_LEN - 1));

	// Next state: power-down wins over a new start but never cuts a conversion
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (pd_s) begin
					state_d = ST_DOWN;
				end else if (cnv_rise) begin
					state_d = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (done) begin
					state_d = pd_s ? ST_DOWN : ST_IDLE;
				end
			end
			ST_DOWN: begin
				if (!pd_s) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (rst_all) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Conversion length counter
	always_ff @(posedge I_CORE_CLK) begin
		if (rst_all || state_q != ST_CONVERT) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CONV_CNT_W'(1);
		end
	end

	// Busy follows the converting state, from a flop
	always_ff @(posedge I_CORE_CLK) begin
		if (rst_all) begin
			O_BUSY <= BUSY_RST;
			O_SAMPLE_HOLD <= 1'b0;
			O_POWERED_DOWN <= PWR_DOWN_RST;
		end else begin
			O_BUSY <= (state_d == ST_CONVERT);
			O_SAMPLE_HOLD <= (state_d == ST_CONVERT);
			O_POWERED_DOWN <= (state_d == ST_DOWN);
		end
	end

	// ****************************************
	// Simultaneous sampling
	// ****************************************
	// One capture strobe for all channels keeps them aligned in time
	always_ff @(posedge I_CORE_CLK) begin
		if (rst_all) begin
			O_RESULT <= '0;
			O_RESULT_VALID <= 1'b0;
		end else begin
			O_RESULT_VALID <= done;
			if (state_q == ST_IDLE && state_d == ST_CONVERT) begin
				for (int i = 0; i < CH; i++) begin
					O_RESULT[i*DW +: DW] <= I_CH_POS[i*DW +: DW] - I_CH_NEG[i*DW +: DW];
				end
			end
		end
	end

	// ****************************************
	// Double power-down global reset
	// ****************************************
	logic pd_armed_q;
	// Armed by a power-down rise, disarmed by any conversion
	always_ff @(posedge I_CORE_CLK) begin
		if (rst_all) begin
			pd_armed_q <= 1'b0;
			glob_rst_q <= 1'b0;
		end else begin
			glob_rst_q <= 1'b0;
			if (state_q == ST_CONVERT) begin
				pd_armed_q <= 1'b0;
			end else if (pd_rise) begin
				if (pd_armed_q) begin
					glob_rst_q <= 1'b1;
					pd_armed_q <= 1'b0;
				end else begin
					pd_armed_q <= 1'b1;
				end
			end
		end
	end

	// Pulse reported out for one cycle; the clearing reset is this same flop
	assign O_GLOBAL_RESET = glob_rst_q;

	// ****************************************
	// I/O mode and echo clock
	// ****************************************
	// Mode pin is a strap; sampled after release so no port feeds a reset value
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			O_DIFF_IO_MODE <= 1'b0;
		end else begin
			O_DIFF_IO_MODE <= mode_s;
		end
	end

	// Busy falling forces the echo clock low; otherwise shifter drives it, gated by chip select
	always_ff @(posedge I_CORE_CLK) begin
		if (rst_all) begin
			O_ECHO_CLOCK_OUTPUT <= 1'b0;
		end else if (state_q == ST_CONVERT && state_d != ST_CONVERT) begin
			O_ECHO_CLOCK_OUTPUT <= 1'b0;
		end else begin
			O_ECHO_CLOCK_OUTPUT <= I_ECHO_CLOCK_NEXT & ~cs_n_s;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_pd_blocks;
		@(posedge I_CORE_CLK) disable iff (rst_all)
		(state_q == ST_DOWN && cnv_rise) |=> !O_BUSY;
	endproperty
	a_pd_blocks: assert property (p_pd_blocks) else $error("start accepted while down");

	property p_finish_first;
		@(posedge I_CORE_CLK) disable iff (rst_all)
		(state_q == ST_CONVERT && pd_s && !done) |=> state_q == ST_CONVERT;
	endproperty
	a_finish_first: assert property (p_finish_first) else $error("conversion cut");

	property p_start_busy;
		@(posedge I_CORE_CLK) disable iff (rst_all)
		(state_q == ST_IDLE && !pd_s && cnv_rise) |=> O_BUSY && O_SAMPLE_HOLD;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start missed");

	property p_busy_len;
		@(posedge I_CORE_CLK) disable iff (rst_all)
		$rose(O_BUSY) |-> O_BUSY [*8];
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy too short");

	property p_echo_low;
		@(posedge I_CORE_CLK) disable iff (rst_all)
		$fell(O_BUSY) |-> !O_ECHO_CLOCK_OUTPUT;
	endproperty
	a_echo_low: assert property (p_echo_low) else $error("echo clock not low");

	property p_mode;
		@(posedge I_CORE_CLK) disable iff (I_RST)
		mode_s |=> O_DIFF_IO_MODE;
	endproperty
	a_mode: assert property (p_mode) else $error("mode not followed");

	property p_valid_busy;
		@(posedge I_CORE_CLK) disable iff (rst_all)
		O_RESULT_VALID |-> $past(O_BUSY) && !O_BUSY;
	endproperty
	a_valid_busy: assert property (p_valid_busy) else $error("result out of step");

	property p_cs_free;
		@(posedge I_CORE_CLK) disable iff (rst_all)
		(cs_n_s && state_q == ST_IDLE && !pd_s && cnv_rise) |=> O_BUSY;
	endproperty
	a_cs_free: assert property (p_cs_free) else $error("start gated by select");

endmodule : conv_power_ctrl

`default_nettype wire

// ---- hdl/pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Two-flop synchroniser for pin inputs
// ****************************************
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	// First stage is read only by the second stage
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : pin_sync

`default_nettype wire

// ---- verif/host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// ****
// Host sequencing conversions
// ****
module host_model (
	// Clock and status
	input wire logic clk,
	input wire logic busy,
	// Pins driven
	output logic start,
	output logic pd
);
	// Pins idle low from time zero
	initial begin
		start = 1'b0;
		pd = 1'b0;
	end

	// Start held 3 cycles so the two-flop sync surely sees it; never while busy
	task automatic pulse_start();
		@(posedge clk);
		while (busy === 1'b1) @(posedge clk);
		start <= 1'b1;
		repeat (3) @(posedge clk);
		start <= 1'b0;
		@(posedge clk);
	endtask : pulse_start

	// Level change on power-down at an edge, one more edge to land
	task automatic set_pd(input logic v);
		@(posedge clk);
		pd <= v;
		@(posedge clk);
	endtask : set_pd
endmodule : host_model

`default_nettype wire

// ---- verif/test_adc_conversion_power_control.sv ----
`timescale 1ns/100ps
`default_nettype none

module test_adc_conversion_power_control;
	localparam int LEN = 10;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mode = 1'b0;
	logic cs_n = 1'b1;
	logic echo_next = 1'b1;
	// Channels 0, 2 and 5 borrow; a whole-word subtraction would leak into channels 1, 3 and 6
	logic [143:0] ch_pos = {18'h00123, 18'h20000, 18'h00055, 18'h1FFFF,
		18'h00300, 18'h00007, 18'h3FFFF, 18'h00001};
	logic [143:0] ch_neg = {18'h00021, 18'h00001, 18'h00100, 18'h00001,
		18'h00300, 18'h00010, 18'h00000, 18'h00002};
	logic start, pd, busy, down, diff, hold, greset, echo, valid;
	logic [143:0] result;
	int errors = 0;
	int samples_checked = 0;

	// ****
	// Clock, design and host
	// ****
	always #4 clk = ~clk;
	conv_power_ctrl #(.CONV_LEN(LEN)) dut (.I_CORE_CLK(clk), .I_RST(rst),
		.I_CONVERSION_START_INPUT(start), .I_POWER_DOWN_INPUT(pd), .I_IO_MODE_SELECT(mode),
		.I_CS_N(cs_n), .I_ECHO_CLOCK_NEXT(echo_next), .I_CH_POS(ch_pos), .I_CH_NEG(ch_neg),
		.O_BUSY(busy), .O_POWERED_DOWN(down), .O_DIFF_IO_MODE(diff), .O_SAMPLE_HOLD(hold),
		.O_GLOBAL_RESET(greset), .O_ECHO_CLOCK_OUTPUT(echo), .O_RESULT(result),
		.O_RESULT_VALID(valid));
	host_model host (.clk(clk), .busy(busy), .start(start), .pd(pd));

	// ****
	// Helpers
	// ****
	task automatic chk(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			errors++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : chk

	// Sample 1 ns past the edge so its updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// Per-channel difference, each channel wrapping within its own 18 bits
	function automatic logic [143:0] diff_of(input logic [143:0] p, input logic [143:0] q);
		logic [143:0] r;
		for (int i = 0; i < 8; i++) begin
			r[i*18 +: 18] = p[i*18 +: 18] - q[i*18 +: 18];
		end
		return r;
	endfunction : diff_of

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out

	// ****
	// Scenarios
	// ****
	task automatic t_mode();
		chk(diff === 1'b0, "mode low");
		@(posedge clk);
		mode <= 1'b1;
		tick(4);
		chk(diff === 1'b1, "mode high");
		$display("mode test done");
	endtask : t_mode

	// Bounded busy count so a stuck busy cannot hang the run
	task automatic t_conv(input logic cs);
		int n;
		logic [143:0] expect_q;
		expect_q = diff_of(ch_pos, ch_neg);
		@(posedge clk);
		cs_n <= cs;
		host.pulse_start();
		#1;
		chk(busy === 1'b1 && hold === 1'b1, "no start");
		chk(echo === ~cs, "echo not gated by select");
		// Inputs move after the start edge; the held samples must not
		@(posedge clk);
		ch_pos <= ~ch_pos;
		tick(0);
		// Busy rose two edges ago
		n = 2;
		while (busy === 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		chk(n == LEN, "busy length");
		chk(valid === 1'b1 && result === expect_q, "result");
		chk(echo === 1'b0, "echo not low at busy fall");
		tick(1);
		chk(valid === 1'b0 && echo === ~cs, "valid or echo after fall");
		@(posedge clk);
		echo_next <= 1'b0;
		tick(1);
		chk(echo === 1'b0, "echo not following shifter");
		@(posedge clk);
		echo_next <= 1'b1;
		$display("conversion test done");
	endtask : t_conv

	task automatic t_pd_mid();
		host.pulse_start();
		host.set_pd(1'b1);
		tick(4);
		chk(busy === 1'b1 && down === 1'b0, "cut short");
		tick(12);
		chk(busy === 1'b0 && down === 1'b1, "not down");
		host.pulse_start();
		tick(6);
		chk(busy === 1'b0 && down === 1'b1, "start taken while down");
		host.set_pd(1'b0);
		tick(6);
		chk(busy === 1'b0 && down === 1'b0, "not powered up");
		$display("power-down test done");
	endtask : t_pd_mid

	task automatic t_reset();
		int seen;
		host.pulse_start();
		tick(14);
		host.set_pd(1'b1);
		seen = 0;
		repeat (10) begin
			tick(1);
			if (greset === 1'b1) seen++;
		end
		chk(seen == 0, "reset despite conversion");
		host.set_pd(1'b0);
		tick(4);
		host.set_pd(1'b1);
		repeat (10) begin
			tick(1);
			if (greset === 1'b1) seen++;
		end
		chk(seen == 1, "no reset pulse");
		host.set_pd(1'b0);
		tick(6);
		chk(diff === 1'b1 && busy === 1'b0 && result === '0, "state after reset");
		// The reset starts the count afresh: a single rise must not reset again
		host.set_pd(1'b1);
		repeat (10) begin
			tick(1);
			if (greset === 1'b1) seen++;
		end
		chk(seen == 1, "reset from a single rise");
		host.set_pd(1'b0);
		tick(6);
		$display("global reset test done");
	endtask : t_reset

	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		tick(2);
		t_mode();
		t_conv(1'b1);
		t_conv(1'b0);
		t_pd_mid();
		t_reset();
		close_out();
	end

	// Watchdog, far beyond the 180 or so cycles the tests need
	initial begin
		repeat (3000) @(posedge clk);
		errors++;
		close_out();
	end
endmodule : test_adc_conversion_power_control

`default_nettype wire
